// *** hw/adc_bank_cfg.svh ***
`ifndef ADC_BANK_CFG_SVH
`define ADC_BANK_CFG_SVH

// Register offsets
`define ADDR_SERIAL_PORT_SETUP 8'h00
`define ADDR_CHIP_IDENTITY 8'h01
`define ADDR_CHANNEL_SELECT 8'h05
`define ADDR_POWER_CONTROL 8'h08
`define ADDR_CLOCK_DIVIDER_SETUP 8'h0B
`define ADDR_SHUFFLE_CONTROL 8'h0C
`define ADDR_COMMIT_SETTINGS 8'hFF

// Reset values
`define RST_SERIAL_PORT_SETUP 8'h18
`define RST_CHANNEL_SELECT 8'hCF
`define RST_POWER_CONTROL 8'h00
`define RST_CLOCK_DIVIDER_SETUP 8'h00
`define RST_SHUFFLE_CONTROL 8'h01

// Identity code, value is arbitrary
`define CHIP_IDENTITY_VALUE 8'h5C

// Field positions
`define SETUP_LSB_HI 6
`define SETUP_SRST_HI 5
`define SETUP_SRST_LO 2
`define SETUP_LSB_LO 1
`define SETUP_FIXED_MASK 8'h18
`define CHSEL_A_BIT 0
`define CHSEL_B_BIT 1
`define CHSEL_ALL_MASK 8'h03
`define PWR_PIN_FN_BIT 5
`define COMMIT_STROBE_BIT 0

`endif

// *** hw/adc_bank_pkg.sv ***
package adc_bank_pkg;

	// Register bank state, one packed word
	typedef struct packed {
		logic [7:0] chan_sel_r;
		logic lsb_first_r;
		logic pin_fn_sh_r;
		logic pin_fn_r;
		logic [5:0] clkdiv_sh_r;
		logic [5:0] clkdiv_r;
		logic [1:0][1:0] pmode_sh_r;
		logic [1:0][1:0] pmode_r;
		logic [1:0][1:0] shuf_sh_r;
		logic [1:0][1:0] shuf_r;
		logic pd_meta_r;
		logic pd_sync_r;
		logic pd_full_r;
		logic pd_standby_r;
		logic [7:0] rd_data_r;
	} bank_state_t;

	// Clock divider state
	typedef struct packed {
		logic [2:0] count_r;
		logic tick_r;
	} div_state_t;

endpackage

// *** hw/clock_ratio_divider.sv ***
`timescale 1ns/10ps
`include "adc_bank_cfg.svh"

module clock_ratio_divider
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [2:0] ratio,
	output logic div_tick
);

	// Registered state and its next value
	adc_bank_pkg::div_state_t st_r;
	adc_bank_pkg::div_state_t st_nxt;

	////////////////////////////////////////////////////////////////////////
	// Count ratio+1 input clocks per output tick
	always_comb
	begin
		st_nxt = st_r;
		// Wrap at the ratio so the period is ratio plus one
		if (st_r.count_r >= ratio)
		begin
			st_nxt.count_r = 3'h0; // R4
			st_nxt.tick_r = 1'b1;
		end
		else
		begin
			st_nxt.count_r = st_r.count_r + 3'h1;
			st_nxt.tick_r = 1'b0;
		end
	end

	// State register
	always_ff @(posedge core_clk)
	begin
		if (reset)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign div_tick = st_r.tick_r;

endmodule

// *** hw/adc_config_register_bank.sv ***
`timescale 1ns/10ps
`include "adc_bank_cfg.svh"
// Operation
// R1: Mirrored setup byte, fixed ones, default 0x18
// R2: Host selects all channels before setup write
// R3: Power pin function: 0 full, 1 standby
// R4: Clock divided by ratio field plus one
// R5: Per-channel shuffle, default enabled
// R6: Unmapped locations ignored, read as zero
// R7: Shadowed settings commit on transfer write
// R8: Local writes reach every selected channel
// R9: Multi-channel reads return channel A copy
// R10: Soft reset restores defaults, self-clears

module adc_config_register_bank
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] wr_data,
	input wire logic pdwn_pin,
	output logic [7:0] rd_data,
	output logic [7:0] channel_select,
	output logic lsb_first,
	output logic [1:0] power_mode_a,
	output logic [1:0] power_mode_b,
	output logic [1:0] shuffle_a,
	output logic [1:0] shuffle_b,
	output logic [2:0] clock_phase,
	output logic clock_div_tick,
	output logic full_power_down,
	output logic standby
);

	// Registered state and its next value
	adc_bank_pkg::bank_state_t st_r;
	adc_bank_pkg::bank_state_t st_nxt;
	// Divided clock tick from the divider
	logic div_tick;

	////////////////////////////////////////////////////////////////////////
	// Defaults, shared by hard reset and soft reset
	// Every field not named below resets to zero, including the pin
	// synchroniser and the read data, so a soft reset also drops a
	// pending power-down until the pin is seen again
	function automatic adc_bank_pkg::bank_state_t defaults();
		adc_bank_pkg::bank_state_t d;
		d = '0;
		// Channel select comes back with both channels enabled
		d.chan_sel_r = `RST_CHANNEL_SELECT;
		// Pin function bit taken from the power control default byte
		d.pin_fn_sh_r = 1'(`RST_POWER_CONTROL >> `PWR_PIN_FN_BIT);
		d.pin_fn_r = d.pin_fn_sh_r;
		// Divider phase and ratio: only six bits are stored
		d.clkdiv_sh_r = 6'(`RST_CLOCK_DIVIDER_SETUP); // R4
		d.clkdiv_r = 6'(`RST_CLOCK_DIVIDER_SETUP);
		// Both channel copies, shadow and live alike
		for (int c = 0; c < 2; c++)
		begin
			d.pmode_sh_r[c] = 2'(`RST_POWER_CONTROL);
			d.pmode_r[c] = 2'(`RST_POWER_CONTROL);
			d.shuf_sh_r[c] = 2'(`RST_SHUFFLE_CONTROL); // R5
			d.shuf_r[c] = 2'(`RST_SHUFFLE_CONTROL);
		end
		return d;
	endfunction

	// Channel whose copy is read back: A whenever A is selected
	// Reading with both channels enabled is legal but only shows A;
	// the host selects one channel to see the B copy
	function automatic int read_chan(input logic [7:0] sel);
		if (sel[`CHSEL_A_BIT])
			return 0; // R9
		else
			return 1;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next-state logic: pin sync, readback, writes, commit
	always_comb
	begin
		int rc;
		rc = read_chan(st_r.chan_sel_r);
		st_nxt = st_r;
		// Two-stage pin synchroniser; the pin is asynchronous to core_clk,
		// so only the second stage feeds any decision
		st_nxt.pd_meta_r = pdwn_pin;
		st_nxt.pd_sync_r = st_r.pd_meta_r;
		// Pin action selected by the committed function bit; a new
		// function written to the shadow does nothing until a commit
		st_nxt.pd_full_r = st_r.pd_sync_r & ~st_r.pin_fn_r; // R3
		st_nxt.pd_standby_r = st_r.pd_sync_r & st_r.pin_fn_r; // R3
		// Readback, zero for open locations; the byte stands for one
		// cycle and falls back to zero when no read is pending
		st_nxt.rd_data_r = 8'h00; // R6
		if (rd_en)
		begin
			if (reg_addr == `ADDR_SERIAL_PORT_SETUP)
			begin
				// Soft reset bits always read back cleared
				st_nxt.rd_data_r = `SETUP_FIXED_MASK; // R1
				st_nxt.rd_data_r[`SETUP_LSB_HI] = st_r.lsb_first_r;
				st_nxt.rd_data_r[`SETUP_LSB_LO] = st_r.lsb_first_r;
			end
			// Fixed identity byte, read only
			else if (reg_addr == `ADDR_CHIP_IDENTITY)
				st_nxt.rd_data_r = `CHIP_IDENTITY_VALUE;
			// Channel select is global and reads back whole
			else if (reg_addr == `ADDR_CHANNEL_SELECT)
				st_nxt.rd_data_r = st_r.chan_sel_r;
			// Shadowed registers read back the shadow, not the live copy
			else if (reg_addr == `ADDR_POWER_CONTROL)
			begin
				// Global pin function bit
				st_nxt.rd_data_r[`PWR_PIN_FN_BIT] = st_r.pin_fn_sh_r;
				// Local mode of the channel picked for reading
				st_nxt.rd_data_r[1:0] = st_r.pmode_sh_r[rc]; // R9
			end
			// Phase in bits 5:3, ratio in bits 2:0
			else if (reg_addr == `ADDR_CLOCK_DIVIDER_SETUP)
				st_nxt.rd_data_r[5:0] = st_r.clkdiv_sh_r;
			// Local shuffle field of the channel picked for reading
			else if (reg_addr == `ADDR_SHUFFLE_CONTROL)
				st_nxt.rd_data_r[1:0] = st_r.shuf_sh_r[rc]; // R9
			// Transfer register reads zero since the bit self-clears
		end
		// Register writes; a write and a read in one cycle are both taken, the read
		// showing the value from before the write; a soft reset write zeroes that read byte
		if (wr_en)
		begin
			if (reg_addr == `ADDR_SERIAL_PORT_SETUP)
			begin
				// Accepted only with every channel selected
				if ((st_r.chan_sel_r & `CHSEL_ALL_MASK) == `CHSEL_ALL_MASK) // R2
				begin
					// Either mirrored copy acts, whatever the shift order
					if (wr_data[`SETUP_SRST_HI] | wr_data[`SETUP_SRST_LO]) // R1
						// Soft reset wins over the rest of the byte
						st_nxt = defaults(); // R10
					else
						// Bit order from either nibble
						st_nxt.lsb_first_r = wr_data[`SETUP_LSB_HI] | wr_data[`SETUP_LSB_LO];
				end
			end
			// Channel select takes effect at once, never shadowed
			else if (reg_addr == `ADDR_CHANNEL_SELECT)
				st_nxt.chan_sel_r = wr_data;
			// Power control: shadowed, committed later
			else if (reg_addr == `ADDR_POWER_CONTROL)
			begin
				// Pin function is global, mode is local
				st_nxt.pin_fn_sh_r = wr_data[`PWR_PIN_FN_BIT]; // R7
				for (int c = 0; c < 2; c++)
					if (st_r.chan_sel_r[c])
						st_nxt.pmode_sh_r[c] = wr_data[1:0]; // R8
			end
			// Divider: global, shadowed; bits 7:6 are open and dropped
			else if (reg_addr == `ADDR_CLOCK_DIVIDER_SETUP)
				st_nxt.clkdiv_sh_r = wr_data[5:0]; // R7
			// Shuffle: local, shadowed, written to each enabled channel
			else if (reg_addr == `ADDR_SHUFFLE_CONTROL)
			begin
				for (int c = 0; c < 2; c++)
					if (st_r.chan_sel_r[c])
						st_nxt.shuf_sh_r[c] = wr_data[1:0]; // R8
			end
			// Commit request
			else if (reg_addr == `ADDR_COMMIT_SETTINGS)
			begin
				// Commit all shadows at once; the strobe is not stored,
				// so the commit bit always reads back as zero
				if (wr_data[`COMMIT_STROBE_BIT])
				begin
					st_nxt.pin_fn_r = st_r.pin_fn_sh_r; // R7
					st_nxt.clkdiv_r = st_r.clkdiv_sh_r;
					st_nxt.pmode_r = st_r.pmode_sh_r;
					st_nxt.shuf_r = st_r.shuf_sh_r;
				end
			end
			// Any other address is ignored
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register; reset is synchronous and loads the same
	// defaults that a soft reset write applies
	always_ff @(posedge core_clk)
	begin
		// Hard reset
		if (reset)
			st_r <= defaults();
		// Normal update
		else
			st_r <= st_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Divider on the committed ratio field; the phase field is passed
	// out unchanged, the sampling logic that uses it lies outside
	clock_ratio_divider u_div
	(
		.core_clk(core_clk),
		.reset(reset),
		.ratio(st_r.clkdiv_r[2:0]), // R4
		.div_tick(div_tick)
	);

	// Outputs straight from flip-flops; the committed copies drive
	// the converter settings, never the shadows
	assign rd_data = st_r.rd_data_r;
	assign channel_select = st_r.chan_sel_r;
	assign lsb_first = st_r.lsb_first_r;
	assign power_mode_a = st_r.pmode_r[0];
	assign power_mode_b = st_r.pmode_r[1];
	assign shuffle_a = st_r.shuf_r[0];
	assign shuffle_b = st_r.shuf_r[1];
	assign clock_phase = st_r.clkdiv_r[5:3];
	assign clock_div_tick = div_tick;
	assign full_power_down = st_r.pd_full_r;
	assign standby = st_r.pd_standby_r;

endmodule

// *** bench/adc_bank_chk.sv ***
`timescale 1ns/10ps
`include "adc_bank_cfg.svh"
module adc_bank_chk
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] wr_data,
	input wire logic pdwn_pin,
	input wire logic [7:0] rd_data,
	input wire logic [7:0] channel_select,
	input wire logic lsb_first,
	input wire logic [1:0] power_mode_a,
	input wire logic [1:0] power_mode_b,
	input wire logic [1:0] shuffle_a,
	input wire logic [1:0] shuffle_b,
	input wire logic [2:0] clock_phase,
	input wire logic full_power_down,
	input wire logic standby
);
	// Commit and soft reset requests
	logic cm;
	logic sr;
	assign cm = wr_en && reg_addr == 8'hFF && wr_data[0];
	assign sr = wr_en && reg_addr == 8'h00 && channel_select[1:0] == 2'h3
		&& (wr_data[5] || wr_data[2]);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_id_read: assert property (rd_en && reg_addr == 8'h01 |=> rd_data == `CHIP_IDENTITY_VALUE)
		else $error("identity read wrong");
	a_rd_idle: assert property (!rd_en |=> rd_data == 8'h00)
		else $error("read data not idle");
	a_setup_ones: assert property (rd_en && reg_addr == 8'h00 |=> rd_data[4:3] == 2'h3)
		else $error("setup fixed ones wrong");
	a_setup_lock: assert property (wr_en && reg_addr == 8'h00 && channel_select[1:0] != 2'h3
		|=> $stable(lsb_first) && $stable(channel_select)) else $error("setup write not refused");
	a_chsel_write: assert property (wr_en && reg_addr == 8'h05 |=> channel_select == $past(wr_data))
		else $error("channel select not stored");
	a_shadow_hold: assert property (!cm && !sr
		|=> $stable({shuffle_a, shuffle_b, power_mode_a, power_mode_b, clock_phase}))
		else $error("setting moved without commit");
	a_srst_defaults: assert property (sr |=> channel_select == 8'hCF && !lsb_first && shuffle_a == 2'h1)
		else $error("soft reset defaults wrong");
	a_pin_idle: assert property (!$past(pdwn_pin, 3) |-> !full_power_down && !standby)
		else $error("power down without pin");
	c_commit: cover property (cm);
	c_srst: cover property (sr);
	c_standby: cover property (standby);
endmodule
bind adc_config_register_bank adc_bank_chk i_chk(.*);

// *** bench/adc_host.sv ***
`timescale 1ns/10ps
// Host side of the register port, drives on falling edges
module adc_host
(
	input wire logic core_clk,
	input wire logic [7:0] rd_data,
	output logic wr_en,
	output logic rd_en,
	output logic [7:0] reg_addr,
	output logic [7:0] wr_data
);
	initial {wr_en, rd_en, reg_addr, wr_data} = 18'h0;
	// One-cycle write pulse, then address and data show junk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		{wr_en, reg_addr, wr_data} = {1'b1, a, d};
		@(negedge core_clk);
		{wr_en, reg_addr, wr_data} = {1'b0, ~a, ~d};
	endtask
	// One-cycle read pulse, data taken the cycle after
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		{rd_en, reg_addr} = {1'b1, a};
		@(negedge core_clk);
		{rd_en, reg_addr} = {1'b0, ~a};
		d = rd_data;
	endtask
endmodule

// *** bench/test_adc_config_register_bank.sv ***
`timescale 1ns/10ps
module test_adc_config_register_bank;
	logic core_clk, reset, pdwn_pin, wr_en, rd_en, lsb_first;
	logic clock_div_tick, full_power_down, standby;
	logic [7:0] reg_addr, wr_data, rd_data, channel_select, v;
	logic [1:0] power_mode_a, power_mode_b, shuffle_a, shuffle_b;
	logic [2:0] clock_phase;
	int bad_count, tests_run, n;
	logic [7:0] ad [8] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h08, 8'h0B, 8'h0C, 8'hFF};
	logic [7:0] ex [8] = '{8'h18, 8'h5C, 8'h00, 8'hCF, 8'h00, 8'h00, 8'h01, 8'h00};
	adc_host i_host(.core_clk(core_clk), .rd_data(rd_data), .wr_en(wr_en), .rd_en(rd_en),
		.reg_addr(reg_addr), .wr_data(wr_data));
	adc_config_register_bank i_dut(.*);
	initial
	begin
		core_clk = 0;
		forever #2.5 core_clk = ~core_clk;
	end
	// Compare and count
	task chk(input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e)
		begin
			bad_count++;
			$display("[ERR] %0t seen %h want %h", $time, s, e);
		end
	endtask
	task stop_test;
		$display("mismatches %0d of %0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Cycles up to the next divider tick, bounded
	task tick_gap;
		n = 0;
		do
		begin
			@(negedge core_clk);
			n++;
		end
		while (!clock_div_tick && n < 40);
		// A missing tick counts as a mismatch and ends the run
		if (n >= 40)
		begin
			bad_count++;
			stop_test;
		end
	endtask
	// Scenario sequence
	initial
	begin
		{reset, pdwn_pin, bad_count, tests_run} = '0;
		reset = 1;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk) reset = 0;
		// Every mapped location and one open location at reset
		foreach (ad[i])
		begin
			i_host.rd(ad[i], v);
			chk(v, ex[i]);
		end
		// Ratio 000 ticks every cycle
		tick_gap;
		tick_gap;
		chk(8'(n), 8'h01);
		// Bit order set through both nibbles
		i_host.wr(8'h00, 8'h42);
		i_host.rd(8'h00, v);
		chk(v, 8'h5A);
		// Setup write with channel B deselected is refused
		i_host.wr(8'h05, 8'h01);
		i_host.wr(8'h00, 8'h00);
		chk(8'(lsb_first), 8'h01);
		// Shuffle off for channel A, held in the shadow until commit
		i_host.wr(8'h0C, 8'h00);
		i_host.rd(8'h0C, v);
		chk(v, 8'h00);
		chk({6'h0, shuffle_a}, 8'h01);
		i_host.wr(8'hFF, 8'h01);
		chk({4'h0, shuffle_a, shuffle_b}, 8'h01);
		i_host.rd(8'hFF, v);
		chk(v, 8'h00);
		// Both channels selected: the A copy is read
		i_host.wr(8'h05, 8'h03);
		i_host.rd(8'h0C, v);
		chk(v, 8'h00);
		i_host.wr(8'h05, 8'h02);
		i_host.rd(8'h0C, v);
		chk(v, 8'h01);
		// Pin as standby, channel B mode set to standby
		i_host.wr(8'h08, 8'h22);
		i_host.rd(8'h08, v);
		chk(v, 8'h22);
		i_host.wr(8'hFF, 8'h01);
		chk({4'h0, power_mode_a, power_mode_b}, 8'h02);
		pdwn_pin = 1;
		repeat (4) @(negedge core_clk);
		chk({6'h0, full_power_down, standby}, 8'h01);
		// Pin as full power-down, channel B mode back to normal
		i_host.wr(8'h08, 8'h00);
		i_host.wr(8'hFF, 8'h01);
		repeat (2) @(negedge core_clk);
		chk({6'h0, full_power_down, standby}, 8'h02);
		chk({4'h0, power_mode_a, power_mode_b}, 8'h00);
		pdwn_pin = 0;
		// Phase 5, ratio 7: divide by eight
		i_host.wr(8'h0B, 8'h2F);
		i_host.wr(8'hFF, 8'h01);
		chk({5'h0, clock_phase}, 8'h05);
		tick_gap;
		tick_gap;
		chk(8'(n), 8'h08);
		// Soft reset through the low nibble copy alone
		i_host.wr(8'h05, 8'h03);
		i_host.wr(8'h00, 8'h04);
		chk(channel_select, 8'hCF);
		chk({2'h0, lsb_first, shuffle_a, clock_phase}, 8'h08);
		i_host.rd(8'h00, v);
		chk(v, 8'h18);
		stop_test;
	end
endmodule
